// file: rtl/drfs_pkg.sv
package drfs_pkg;
  // ==========================================================
  // Widths and codes
  localparam int FREQ_W = 16;
  localparam int OFS_W = FREQ_W + 2;
  localparam int MFI_NUM = 7;
  localparam int MFO_NUM = 3;
  localparam int MFI_FUNC_W = 6;
  localparam int MFO_FUNC_W = 5;
  localparam int RETRY_CNT_W = 4;
  localparam int ERR_CNT_W = 28;
  localparam int RETRY_TMR_W = 38;
  localparam logic [MFO_FUNC_W-1:0] MFO_FREQ_GE = 5'h04;
  localparam logic [MFO_FUNC_W-1:0] MFO_FREQ_LE = 5'h05;
  localparam logic [MFI_FUNC_W-1:0] MFI_OFS_1 = 6'h1e;
  localparam logic [MFI_FUNC_W-1:0] MFI_OFS_2 = 6'h1f;
  localparam logic [MFI_FUNC_W-1:0] MFI_OFS_3 = 6'h21;
  localparam logic TORQ_SRC_TORQUE = 1'b0;
  localparam logic TORQ_SRC_CURRENT = 1'b1;
  // ==========================================================
  // Parameter store
  localparam logic [1:0] PSEL_JUMP_1 = 2'h0;
  localparam logic [1:0] PSEL_JUMP_2 = 2'h1;
  localparam logic [1:0] PSEL_JUMP_3 = 2'h2;
  localparam logic [1:0] PSEL_OFS_MODE = 2'h3;
  localparam logic [FREQ_W-1:0] JUMP_FREQ_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_LIMIT_HZ = 16'h9c40;
  localparam logic [FREQ_W-1:0] FREQ_LIMIT_PCT = 16'h2710;
  localparam logic [31:0] PCT_DIVISOR = 32'h0000_2710;
  localparam logic [FREQ_W-1:0] OFS_MODE_DIGIT_BASE = 16'h000a;
  localparam logic [FREQ_W-1:0] OFS_MODE_LIMIT = 16'h001e;
  localparam logic [1:0] OFS_X_JUMP = 2'h0;
  localparam logic [1:0] OFS_X_HZ = 2'h1;
  localparam logic [1:0] OFS_X_PCT = 2'h2;
  localparam logic [1:0] OFS_X_RST = 2'h0;
  localparam logic [3:0] OFS_Y_RST = 4'h0;
  localparam logic [3:0] OFS_Y_NEG3 = 4'h4;
  localparam logic [3:0] OFS_Y_ALLNEG = 4'h8;
  localparam logic [RETRY_CNT_W-1:0] RETRY_LIMIT_MAX = 4'ha;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint ERR_SHOW_MS = 1000;
  localparam longint ERR_CYCLES = ERR_SHOW_MS * CLK_HZ / 1000;
  localparam longint RETRY_CLEAR_MIN = 10;
  localparam longint RETRY_CLEAR_CYCLES = RETRY_CLEAR_MIN * 60 * CLK_HZ;
endpackage : drfs_pkg

// file: rtl/drfs_retry_if.sv
`timescale 1ns/1ps
interface drfs_retry_if;
  import drfs_pkg::*;
  logic fault_oc;
  logic fault_ov;
  logic fault_other;
  logic fault_rst;
  logic [RETRY_CNT_W-1:0] limit;
  logic [RETRY_CNT_W-1:0] count;
  logic restart;
  logic hold;
  modport ctl (output fault_oc, fault_ov, fault_other, fault_rst, limit,
               input count, restart, hold);
  modport cnt (input fault_oc, fault_ov, fault_other, fault_rst, limit,
               output count, restart, hold);
endinterface : drfs_retry_if

// file: rtl/drfs_retry.sv
`timescale 1ns/1ps
module drfs_retry
  import drfs_pkg::*;
#(
  parameter longint CLEAR_CYCLES = RETRY_CLEAR_CYCLES
)(
  input wire logic mclk_in,     // Control clock
  input wire logic arst_n_in,   // Async reset, low
  drfs_retry_if.cnt rif         // Fault and retry signals
);
  logic [RETRY_CNT_W-1:0] count_q;
  logic [RETRY_TMR_W-1:0] tmr_q;
  logic seen_q;
  logic restart_q;
  logic hold_q;
  logic retry_evt;
  logic [RETRY_CNT_W-1:0] lim;

  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (64'h1 << RETRY_TMR_W))
    $error("drfs_retry: CLEAR_CYCLES out of range");

  assign retry_evt = rif.fault_oc | rif.fault_ov;
  assign lim = (rif.limit > RETRY_LIMIT_MAX) ? RETRY_LIMIT_MAX : rif.limit;

  // ==========================================================
  // Attempt counter; a new fault wins over a clear
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      count_q <= '0;
      seen_q <= 1'b0;
      restart_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      restart_q <= 1'b0;
      if (retry_evt)
      begin
        seen_q <= 1'b1;
        if (count_q < lim)
        begin
          count_q <= count_q + 1'b1;
          restart_q <= 1'b1;
        end
        else
          hold_q <= 1'b1;
      end
      else if (rif.fault_other)
      begin
        seen_q <= 1'b1;
        hold_q <= 1'b1;
      end
      else if (rif.fault_rst && seen_q)
      begin
        count_q <= '0;
        seen_q <= 1'b0;
        hold_q <= 1'b0;
      end
      else if (tmr_q == RETRY_TMR_W'(1))
        count_q <= '0;
    end

  // ==========================================================
  // Quiet-period timer, armed by each retry
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      tmr_q <= '0;
    else if (retry_evt && count_q < lim)
      tmr_q <= RETRY_TMR_W'(CLEAR_CYCLES);
    else if (retry_evt || rif.fault_other)
      tmr_q <= '0;
    else if (tmr_q != '0)
      tmr_q <= tmr_q - 1'b1;

  assign rif.count = count_q;
  assign rif.restart = restart_q;
  assign rif.hold = hold_q;

  restart_cause_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      rif.restart |-> $past(rif.fault_oc || rif.fault_ov))
    else $error("retry restart without overcurrent or overvoltage");
  count_bound_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      rif.count <= RETRY_LIMIT_MAX)
    else $error("retry count above ten");
  reset_clear_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (rif.fault_rst && seen_q && !retry_evt && !rif.fault_other)
      |=> (rif.count == '0 && !rif.hold))
    else $error("fault reset did not clear retry count");
  sat_hold_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (retry_evt && count_q >= lim) |=> (rif.hold && !rif.restart && $stable(rif.count)))
    else $error("saturated retry count did not hold fault");
endmodule : drfs_retry

// file: rtl/drfs_top.sv
// Notes on behaviour
// - Vector mode: selector 0 picks torque, 1 picks current for torque detect.
// - V/f mode ignores selector; detection always uses output current.
// - Output code 4 asserts while output frequency >= detection level.
// - Output code 5 asserts while output frequency <= detection level.
// - A jump frequency of zero disables its band.
// - Misordered jump write: error shown one second, jumps restored to initial.
// - No steady running inside enabled bands; ramps pass through them.
// - Retry limit settable zero to ten; each attempt resets fault and restarts.
// - Only overcurrent or overvoltage faults trigger retry.
// - Retry count clears after ten fault-free minutes following a retry.
// - Retry count clears on fault reset after a fault, and at power-up.
// - With offsets enabled, selected offsets add to or subtract from reference.
// - First digit: 0 jumps, 1 offsets in Hz, 2 offsets in percent.
// - Digit 0/1: 0.01 Hz up to 400 Hz; digit 2: 0.01% up to 100%.
// - Second digit 0..3: sign of offsets 1 and 2; offset 3 positive.
// - Constants reset to zero, offset mode to 0: jumps active.
// - Terminal codes 30, 31, 33 activate offset inputs 1 to 3.
// - Final offset sums signed constants of asserted inputs, else zero.
// - Second digit 4..7 makes offset 3 negative; 8 and 9 all negative.
`timescale 1ns/1ps
module drfs_top
  import drfs_pkg::*;
#(
  parameter longint ERR_SHOW_CYCLES = ERR_CYCLES,
  parameter longint RETRY_QUIET_CYCLES = RETRY_CLEAR_CYCLES
)(
  input wire logic mclk_in,                                 // Control clock
  input wire logic arst_n_in,                               // Async reset, low
  input wire logic control_vector_in,                       // 1 vector, 0 V/f
  input wire logic torque_detect_source_sel_in,             // 0 torque, 1 current
  input wire logic [FREQ_W-1:0] output_torque_in,           // Output torque
  input wire logic [FREQ_W-1:0] output_current_in,          // Output current
  output logic [FREQ_W-1:0] torque_detect_qty_out,          // Detection quantity
  output logic torque_detect_by_current_out,                // Current is source
  input wire logic [FREQ_W-1:0] output_freq_in,             // Output freq, 0.01 Hz
  input wire logic [FREQ_W-1:0] freq_detect_level_in,       // Detection level
  input wire logic [MFO_FUNC_W-1:0] mf_output_1_func_in,    // Output 1 function
  input wire logic [MFO_FUNC_W-1:0] mf_output_2_func_in,    // Output 2 function
  input wire logic [MFO_FUNC_W-1:0] mf_output_3_func_in,    // Output 3 function
  output logic [MFO_NUM-1:0] mf_output_out,                 // Frequency detect flags
  input wire logic param_wr_in,                             // Parameter write strobe
  input wire logic [1:0] param_sel_in,                      // Parameter select
  input wire logic [FREQ_W-1:0] param_data_in,              // Parameter value
  output logic param_error_out,                             // Error indication
  output logic [FREQ_W-1:0] jump_offset_freq_1_out,         // Constant 1
  output logic [FREQ_W-1:0] jump_offset_freq_2_out,         // Constant 2
  output logic [FREQ_W-1:0] jump_offset_freq_3_out,         // Constant 3
  input wire logic [FREQ_W-1:0] jump_width_in,              // Band half width
  input wire logic [FREQ_W-1:0] max_output_freq_in,         // Max output freq
  input wire logic [FREQ_W-1:0] freq_ref_in,                // Raw reference
  output logic [FREQ_W-1:0] freq_ref_out,                   // Shaped reference
  output logic signed [OFS_W-1:0] offset_amount_out,        // Final offset
  input wire logic [MFI_NUM*MFI_FUNC_W-1:0] mf_input_func_select_in, // Terminal funcs
  input wire logic [MFI_NUM-1:0] mf_terminal_in,            // Terminal pins
  input wire logic overcurrent_fault_in,                    // Fault pulse
  input wire logic overvoltage_fault_in,                    // Fault pulse
  input wire logic other_fault_in,                          // Fault pulse
  input wire logic fault_reset_in,                          // Fault reset pin
  input wire logic [RETRY_CNT_W-1:0] retry_count_limit_in,  // Retry limit
  output logic retry_restart_out,                           // Restart pulse
  output logic [RETRY_CNT_W-1:0] retry_count_out,           // Attempts made
  output logic fault_hold_out                               // Stopped in fault
);
  if (ERR_SHOW_CYCLES < 1 || ERR_SHOW_CYCLES >= (64'h1 << ERR_CNT_W))
    $error("drfs_top: ERR_SHOW_CYCLES out of range");

  // ==========================================================
  // Pin synchronisers
  logic [MFI_NUM-1:0] term_s1_q;
  logic [MFI_NUM-1:0] term_s2_q;
  logic frst_s1_q;
  logic frst_s2_q;

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      term_s1_q <= '0;
      term_s2_q <= '0;
      frst_s1_q <= 1'b0;
      frst_s2_q <= 1'b0;
    end
    else
    begin
      term_s1_q <= mf_terminal_in;
      term_s2_q <= term_s1_q;
      frst_s1_q <= fault_reset_in;
      frst_s2_q <= frst_s1_q;
    end

  // ==========================================================
  // Torque detection source
  logic use_current;
  assign use_current = !control_vector_in
    || (torque_detect_source_sel_in == TORQ_SRC_CURRENT);

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      torque_detect_qty_out <= '0;
      torque_detect_by_current_out <= 1'b1;
    end
    else
    begin
      torque_detect_qty_out <= use_current ? output_current_in : output_torque_in;
      torque_detect_by_current_out <= use_current;
    end

  // ==========================================================
  // Frequency detection outputs
  logic [MFO_FUNC_W-1:0] mfo_func [MFO_NUM];
  assign mfo_func[0] = mf_output_1_func_in;
  assign mfo_func[1] = mf_output_2_func_in;
  assign mfo_func[2] = mf_output_3_func_in;

  for (genvar i = 0; i < MFO_NUM; i++)
  begin : g_mfo
    always_ff @(posedge mclk_in or negedge arst_n_in)
      if (!arst_n_in)
        mf_output_out[i] <= 1'b0;
      else
        mf_output_out[i] <=
          (mfo_func[i] == MFO_FREQ_GE && output_freq_in >= freq_detect_level_in)
          || (mfo_func[i] == MFO_FREQ_LE && output_freq_in <= freq_detect_level_in);
  end

  // ==========================================================
  // Parameter store
  logic [FREQ_W-1:0] jf_q [3];
  logic [1:0] ofs_x_q;
  logic [3:0] ofs_y_q;
  logic [ERR_CNT_W-1:0] err_cnt_q;
  logic [FREQ_W-1:0] jf_new [3];
  logic [FREQ_W-1:0] freq_limit;
  logic wr_jump;
  logic order_bad;

  assign freq_limit = (ofs_x_q == OFS_X_PCT) ? FREQ_LIMIT_PCT : FREQ_LIMIT_HZ;
  assign wr_jump = param_wr_in && param_sel_in != PSEL_OFS_MODE
    && param_data_in <= freq_limit;

  always_comb
  begin
    for (int k = 0; k < 3; k++)
      jf_new[k] = (wr_jump && param_sel_in == 2'(k)) ? param_data_in : jf_q[k];
    order_bad = !(jf_new[0] >= jf_new[1] && jf_new[1] >= jf_new[2]);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      for (int k = 0; k < 3; k++)
        jf_q[k] <= JUMP_FREQ_RST;
      ofs_x_q <= OFS_X_RST;
      ofs_y_q <= OFS_Y_RST;
    end
    else if (wr_jump)
    begin
      for (int k = 0; k < 3; k++)
        jf_q[k] <= order_bad ? JUMP_FREQ_RST : jf_new[k];
    end
    else if (param_wr_in && param_sel_in == PSEL_OFS_MODE && param_data_in < OFS_MODE_LIMIT)
    begin
      ofs_x_q <= 2'(param_data_in / OFS_MODE_DIGIT_BASE);
      ofs_y_q <= 4'(param_data_in % OFS_MODE_DIGIT_BASE);
      for (int k = 0; k < 3; k++)
        jf_q[k] <= JUMP_FREQ_RST;
    end

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      err_cnt_q <= '0;
    else if (wr_jump && order_bad)
      err_cnt_q <= ERR_CNT_W'(ERR_SHOW_CYCLES);
    else if (err_cnt_q != '0)
      err_cnt_q <= err_cnt_q - 1'b1;

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      param_error_out <= 1'b0;
    else
      param_error_out <= (wr_jump && order_bad) || err_cnt_q > ERR_CNT_W'(1);

  assign jump_offset_freq_1_out = jf_q[0];
  assign jump_offset_freq_2_out = jf_q[1];
  assign jump_offset_freq_3_out = jf_q[2];

  // ==========================================================
  // Offset inputs, signs and band limits per constant
  logic [2:0] ofs_in;
  logic [2:0] ofs_neg;
  logic [MFI_FUNC_W-1:0] ofs_code [3];
  logic signed [OFS_W-1:0] ofs_term [3];
  logic [FREQ_W-1:0] band_lo [3];
  logic [FREQ_W:0] band_hi [3];
  logic [2:0] in_band;
  logic [FREQ_W-1:0] ref_clamped;
  logic ofs_en;

  assign ofs_code[0] = MFI_OFS_1;
  assign ofs_code[1] = MFI_OFS_2;
  assign ofs_code[2] = MFI_OFS_3;
  assign ofs_en = (ofs_x_q == OFS_X_HZ) || (ofs_x_q == OFS_X_PCT);
  assign ofs_neg[0] = ofs_y_q[0] || ofs_y_q >= OFS_Y_ALLNEG;
  assign ofs_neg[1] = ofs_y_q[1] || ofs_y_q >= OFS_Y_ALLNEG;
  assign ofs_neg[2] = ofs_y_q >= OFS_Y_NEG3;

  for (genvar k = 0; k < 3; k++)
  begin : g_const
    logic [MFI_NUM-1:0] hit;
    logic [31:0] prod;
    logic [FREQ_W-1:0] mag;
    for (genvar t = 0; t < MFI_NUM; t++)
    begin : g_term
      assign hit[t] = term_s2_q[t]
        && mf_input_func_select_in[t*MFI_FUNC_W +: MFI_FUNC_W] == ofs_code[k];
    end
    assign ofs_in[k] = |hit;
    assign prod = jf_q[k] * max_output_freq_in;
    assign mag = (ofs_x_q == OFS_X_PCT) ? FREQ_W'(prod / PCT_DIVISOR) : jf_q[k];
    assign ofs_term[k] = !ofs_in[k] ? '0
      : ofs_neg[k] ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
    assign band_lo[k] = (jf_q[k] > jump_width_in) ? jf_q[k] - jump_width_in : '0;
    assign band_hi[k] = {1'b0, jf_q[k]} + {1'b0, jump_width_in};
    assign in_band[k] = ofs_x_q == OFS_X_JUMP && jf_q[k] != '0
      && ref_clamped >= band_lo[k] && {1'b0, ref_clamped} <= band_hi[k];
  end

  // ==========================================================
  // Reference shaping
  logic signed [OFS_W-1:0] ofs_sum;
  logic signed [OFS_W:0] ref_sum;
  logic [FREQ_W-1:0] ref_jumped;

  always_comb
  begin
    ofs_sum = ofs_en ? ofs_term[0] + ofs_term[1] + ofs_term[2] : '0;
    ref_sum = $signed({3'b000, freq_ref_in}) + (OFS_W+1)'(ofs_sum);
    if (ref_sum < 0)
      ref_clamped = '0;
    else if (ref_sum > $signed({3'b000, FREQ_LIMIT_HZ}))
      ref_clamped = FREQ_LIMIT_HZ;
    else
      ref_clamped = FREQ_W'(ref_sum);
    ref_jumped = ref_clamped;
    // The ramp outside still sweeps through a band; only the target leaves it
    for (int k = 2; k >= 0; k--)
      if (in_band[k])
        ref_jumped = band_lo[k];
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      freq_ref_out <= '0;
      offset_amount_out <= '0;
    end
    else
    begin
      freq_ref_out <= ref_jumped;
      offset_amount_out <= ofs_sum;
    end

  // ==========================================================
  // Retry counter
  drfs_retry_if rif ();
  assign rif.fault_oc = overcurrent_fault_in;
  assign rif.fault_ov = overvoltage_fault_in;
  assign rif.fault_other = other_fault_in;
  assign rif.fault_rst = frst_s2_q;
  assign rif.limit = retry_count_limit_in;

  drfs_retry #(.CLEAR_CYCLES(RETRY_QUIET_CYCLES)) u_retry (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .rif(rif.cnt)
  );

  assign retry_restart_out = rif.restart;
  assign retry_count_out = rif.count;
  assign fault_hold_out = rif.hold;

  // ==========================================================
  // Checks
  freq_ge_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (mf_output_1_func_in == MFO_FREQ_GE)
      |=> mf_output_out[0] == ($past(output_freq_in) >= $past(freq_detect_level_in)))
    else $error("frequency detect 1 wrong");
  freq_le_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (mf_output_2_func_in == MFO_FREQ_LE)
      |=> mf_output_out[1] == ($past(output_freq_in) <= $past(freq_detect_level_in)))
    else $error("frequency detect 2 wrong");
  vf_current_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      !control_vector_in |=> torque_detect_qty_out == $past(output_current_in))
    else $error("V/f mode not using current");
  vec_torque_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (control_vector_in && torque_detect_source_sel_in == TORQ_SRC_TORQUE)
      |=> torque_detect_qty_out == $past(output_torque_in))
    else $error("vector mode not using torque");
  order_err_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (wr_jump && order_bad) |=> param_error_out [*8]
      ##0 (jump_offset_freq_1_out == JUMP_FREQ_RST && jump_offset_freq_3_out == JUMP_FREQ_RST))
    else $error("misordered jump write not flagged");
  no_offset_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (ofs_in == 3'h0 || !ofs_en) |=> offset_amount_out == '0)
    else $error("offset nonzero with none selected");
  zero_band_a:
    assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (jf_q[0] == '0 && jf_q[1] == '0 && jf_q[2] == '0 && ofs_x_q == OFS_X_JUMP
       && freq_ref_in <= FREQ_LIMIT_HZ) |=> freq_ref_out == $past(freq_ref_in))
    else $error("disabled band altered reference");
endmodule : drfs_top

// file: tb/drfs_drive_model.sv
`timescale 1ns/1ps
module drfs_drive_model
  import drfs_pkg::*;
#(
  parameter int STEP = 250
)(
  input wire logic mclk_in, // Control clock
  input wire logic [FREQ_W-1:0] target_in, // Commanded frequency
  output logic [FREQ_W-1:0] output_freq_out, // Ramped output frequency
  output logic [FREQ_W-1:0] output_torque_out, // Torque feedback
  output logic [FREQ_W-1:0] output_current_out // Current feedback
);
  int f = 0;
  // ==========================================================
  // Ramp toward the command, crossing any band on the way
  always @(negedge mclk_in)
  begin
    if (f + STEP <= int'(target_in))
      f <= f + STEP;
    else if (f >= int'(target_in) + STEP)
      f <= f - STEP;
    else
      f <= int'(target_in);
  end
  assign output_freq_out = f[FREQ_W-1:0];
  assign output_torque_out = ~output_freq_out;
  assign output_current_out = output_freq_out ^ 16'h0f0f;
endmodule : drfs_drive_model

// file: tb/drive_freq_ref_supervision_test.sv
`timescale 1ns/1ps
module drive_freq_ref_supervision_test;
  import drfs_pkg::*;
  localparam int ERR_N = 20;
  localparam int QUIET_N = 50;
  logic mclk_in, arst_n_in, control_vector_in, torque_detect_source_sel_in, param_wr_in;
  logic overcurrent_fault_in, overvoltage_fault_in, other_fault_in, fault_reset_in;
  logic [FREQ_W-1:0] output_torque_in, output_current_in, output_freq_in, target;
  logic [FREQ_W-1:0] param_data_in, jump_width_in, max_output_freq_in, freq_ref_in;
  logic [FREQ_W-1:0] freq_detect_level_in, torque_detect_qty_out, freq_ref_out;
  logic [FREQ_W-1:0] jump_offset_freq_1_out, jump_offset_freq_2_out, jump_offset_freq_3_out;
  logic [MFO_FUNC_W-1:0] mf_output_1_func_in, mf_output_2_func_in, mf_output_3_func_in;
  logic [MFO_NUM-1:0] mf_output_out;
  logic [1:0] param_sel_in;
  logic signed [OFS_W-1:0] offset_amount_out;
  logic [MFI_NUM*MFI_FUNC_W-1:0] mf_input_func_select_in;
  logic [MFI_NUM-1:0] mf_terminal_in;
  logic [RETRY_CNT_W-1:0] retry_count_limit_in, retry_count_out;
  logic torque_detect_by_current_out, param_error_out, retry_restart_out, fault_hold_out;
  int n_errors, comparisons, cnt, lim, hold, n, e, y;
  int rin[4] = '{2950, 2050, 50, 1000};
  int rex[4] = '{2900, 1900, 50, 1000};

  drfs_top #(.ERR_SHOW_CYCLES(ERR_N), .RETRY_QUIET_CYCLES(QUIET_N)) drfs_top_i (.*);
  drfs_drive_model drfs_drive_model_i (.mclk_in(mclk_in), .target_in(target),
    .output_freq_out(output_freq_in), .output_torque_out(output_torque_in),
    .output_current_out(output_current_in));

  task automatic chk_v(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, g);
    end
  endtask : chk_v

  task automatic chk_f(input string nm, input logic ex, input logic g);
    chk_v(nm, {31'h0, ex}, {31'h0, g});
  endtask : chk_f

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [1:0] s, input int d);
    @(negedge mclk_in);
    param_wr_in = 1'b1;
    param_sel_in = s;
    param_data_in = d[FREQ_W-1:0];
    @(negedge mclk_in);
    param_wr_in = 1'b0;
  endtask : wr

  // Fault kind: 0 overcurrent, 1 overvoltage, 2 other
  task automatic flt(input int k);
    logic rs;
    @(negedge mclk_in);
    {other_fault_in, overvoltage_fault_in, overcurrent_fault_in} = 3'b001 << k;
    @(negedge mclk_in);
    {other_fault_in, overvoltage_fault_in, overcurrent_fault_in} = 3'b000;
    rs = (k < 2) && (cnt < lim);
    if (rs)
      cnt++;
    else
      hold = 1;
    chk_f("restart", rs, retry_restart_out);
    chk_f("hold", hold[0], fault_hold_out);
    chk_v("count", cnt, retry_count_out);
  endtask : flt

  task automatic frst();
    @(negedge mclk_in);
    fault_reset_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    fault_reset_in = 1'b0;
    cnt = 0;
    hold = 0;
    chk_v("count", cnt, retry_count_out);
    chk_f("hold", 1'b0, fault_hold_out);
  endtask : frst

  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'h89b1));
    {arst_n_in, control_vector_in, torque_detect_source_sel_in, param_wr_in, param_sel_in,
     overcurrent_fault_in, overvoltage_fault_in, other_fault_in, fault_reset_in, target,
     param_data_in, jump_width_in, max_output_freq_in, freq_ref_in, freq_detect_level_in,
     mf_output_1_func_in, mf_output_2_func_in, mf_output_3_func_in, mf_input_func_select_in,
     mf_terminal_in, retry_count_limit_in} = '0;
    repeat (12) @(negedge mclk_in);
    arst_n_in = 1'b1;
    @(negedge mclk_in);
    chk_v("const1", 0, jump_offset_freq_1_out);
    chk_v("count", 0, retry_count_out);
    chk_f("by_current", 1'b1, torque_detect_by_current_out);
    $display("Reset values done");
    mf_output_1_func_in = MFO_FREQ_GE;
    mf_output_2_func_in = MFO_FREQ_LE;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk_in);
      {torque_detect_source_sel_in, control_vector_in} = 2'(i);
      mf_output_3_func_in = 5'(4 + i % 3);
      freq_detect_level_in = 16'($urandom_range(9000, 1000));
      target = (i == 5) ? freq_detect_level_in : 16'($urandom_range(10000, 0));
      repeat (40)
      begin
        @(posedge mclk_in);
        #1;
        e = (mf_output_3_func_in == MFO_FREQ_GE) ? (output_freq_in >= freq_detect_level_in)
          : (mf_output_3_func_in == MFO_FREQ_LE) && (output_freq_in <= freq_detect_level_in);
        chk_v("mfo", {e[0], output_freq_in <= freq_detect_level_in,
          output_freq_in >= freq_detect_level_in}, mf_output_out);
        e = !(control_vector_in && !torque_detect_source_sel_in);
        chk_f("by_current", e[0], torque_detect_by_current_out);
        chk_v("qty", e ? output_current_in : output_torque_in, torque_detect_qty_out);
      end
    end
    $display("Detection done");
    jump_width_in = 16'h0064;
    max_output_freq_in = 16'h1770;
    wr(PSEL_JUMP_1, 3000);
    wr(PSEL_JUMP_2, 2000);
    chk_v("const2", 2000, jump_offset_freq_2_out);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge mclk_in);
      freq_ref_in = rin[k][FREQ_W-1:0];
      @(posedge mclk_in);
      #1;
      chk_v("ref", rex[k], freq_ref_out);
    end
    wr(PSEL_JUMP_3, 2500);
    chk_v("const1", 0, jump_offset_freq_1_out);
    n = 0;
    while (param_error_out === 1'b1 && n < 100)
    begin
      n++;
      @(negedge mclk_in);
    end
    chk_v("err_len", ERR_N, n);
    $display("Jump bands done");
    mf_input_func_select_in = {24'h0, MFI_OFS_3, MFI_OFS_2, MFI_OFS_1};
    freq_ref_in = 16'h1388;
    for (int m = 10; m < 30; m++)
    begin
      wr(PSEL_OFS_MODE, m);
      wr(PSEL_JUMP_1, 400);
      wr(PSEL_JUMP_2, 200);
      wr(PSEL_JUMP_3, 100);
      mf_terminal_in = 7'($urandom);
      repeat (4) @(negedge mclk_in);
      e = 0;
      y = m % 10;
      for (int k = 0; k < 3; k++)
        if (mf_terminal_in[k])
          e += ((m >= 20) ? (400 >> k) * 6000 / 10000 : (400 >> k)) *
            (((y >= 8) || (k < 2 ? y[k] : y >= 4)) ? -1 : 1);
      chk_v("offset", e, offset_amount_out);
      chk_v("ref", 5000 + e, freq_ref_out);
    end
    // Percent mode refuses a constant above 100.00 %
    wr(PSEL_JUMP_3, 10001);
    chk_v("const3", 100, jump_offset_freq_3_out);
    $display("Offsets done");
    retry_count_limit_in = 4'hf;
    lim = 10;
    for (int i = 0; i < 11; i++)
      flt(i % 2);
    frst();
    flt(2);
    frst();
    retry_count_limit_in = 4'h3;
    lim = 3;
    flt(0);
    // Count must survive to the last quiet cycle and clear right after it
    repeat (QUIET_N - 1) @(negedge mclk_in);
    chk_v("count", 1, retry_count_out);
    @(negedge mclk_in);
    chk_v("count", 0, retry_count_out);
    $display("Retry done");
    close_out();
  end
endmodule : drive_freq_ref_supervision_test
